// file: inc/sensor_cfg_pkg.sv
// Purpose: Shared constants and types for the interrupt routing and
//          proximity filter block.
// Assumes: Eight-bit register port behind the serial bus front end.
// Notes:   Bit positions index the two configuration registers.
//
// What this block does
// - With light level mode set, the interrupt pin follows the live light threshold state, needing no clear.
// - In light level mode the pin asserts when clear leaves the window and releases when it returns.
// - With light level on aux pin set, the light level state shows on the aux pin instead of the irq pin.
// - With near level mode set, the irq pin asserts once the near result rises above the upper threshold.
// - In near level mode the pin releases only when the near result falls below the lower threshold.
// - With near level on aux pin set, the near level state shows on the aux pin instead of the irq pin.
// - With abort on disruption set, a running light integration is aborted during gesture or pattern sending.
// - With abort on disruption set, when gesture or pattern sending ends, a new light integration starts at once, skipping the wait.
// - Infrared compensation off resets to one; at zero, ir=(r+g+b-c)/2 is subtracted from every channel.
// - With decimate clear, a moving window updates the near result and check on every sample once the window has filled.
// - The length bit selects averaging of two samples at zero and four samples at one.
// - With averaging enabled consecutive samples are averaged, otherwise raw samples pass.
package sensor_cfg_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ROUTING_OFFSET    = 8'hAC;
  localparam logic [7:0] PROCESSING_OFFSET = 8'hAD;
  localparam logic [7:0] ROUTING_MASK      = 8'hF0;
  localparam logic [7:0] PROCESSING_MASK   = 8'h2F;
  localparam logic [7:0] ROUTING_RESET     = 8'h00;
  localparam logic [7:0] PROCESSING_RESET  = 8'h08;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int LIGHT_LEVEL_BIT  = 7;
  localparam int LIGHT_AUX_BIT    = 6;
  localparam int NEAR_LEVEL_BIT   = 5;
  localparam int NEAR_AUX_BIT     = 4;
  localparam int ABORT_BIT        = 5;
  localparam int IRCOMP_OFF_BIT   = 3;
  localparam int DECIMATE_BIT     = 2;
  localparam int LENGTH_BIT       = 1;
  localparam int AVG_ENABLE_BIT   = 0;

  // ****************************************
  // Data types and channel order
  // ****************************************
  localparam int COLOR_W = 16;
  localparam int NEAR_W  = 8;
  localparam int CH_CLEAR = 0;
  localparam int CH_COUNT = 4;
  typedef logic [COLOR_W-1:0]               color_type;
  typedef logic [CH_COUNT-1:0][COLOR_W-1:0] color_set_type;
  typedef logic [NEAR_W-1:0]                near_type;

  // ****************************************
  // Averaging
  // ****************************************
  localparam logic [1:0] SHORT_LAST  = 2'd1;
  localparam logic [1:0] LONG_LAST   = 2'd3;
  localparam int         SHORT_SHIFT = 1;
  localparam int         LONG_SHIFT  = 2;
  localparam int         HIST_DEPTH  = 3;

endpackage

// file: inc/near_path_if.sv
// Purpose: Carries near samples, filter settings and filtered results.
// Assumes: One clock domain shared by both ends.
// Notes:   The filter end drives only the result signals.
interface near_path_if;
  logic                     sample_valid;
  sensor_cfg_pkg::near_type sample;
  logic                     avg_enable;
  logic                     avg_long;
  logic                     decimate;
  logic                     result_valid;
  sensor_cfg_pkg::near_type result;

  modport filter (
    input  sample_valid,
    input  sample,
    input  avg_enable,
    input  avg_long,
    input  decimate,
    output result_valid,
    output result
  );

  modport user (
    output sample_valid,
    output sample,
    output avg_enable,
    output avg_long,
    output decimate,
    input  result_valid,
    input  result
  );
endinterface

// file: hw/color_ir_correct.sv
// Purpose: Infrared compensation of the four light channels.
// Assumes: Raw channels are stable while the caller samples the output.
// Notes:   Results saturate to the channel range instead of wrapping.
module color_ir_correct (
  // Control
  input  wire logic                          comp_off,
  // Channels, clear first
  input  wire sensor_cfg_pkg::color_set_type raw,
  output sensor_cfg_pkg::color_set_type      corrected
);

  // ****************************************
  // Infrared estimate
  // ****************************************
  logic        [17:0] sum_rgb;
  logic signed [18:0] ir_wide;
  logic signed [18:0] ir_half;

  // Red, green and blue sum less clear, halved with sign kept
  assign sum_rgb = {2'b00, raw[1]} + {2'b00, raw[2]} + {2'b00, raw[3]};
  assign ir_wide = $signed({1'b0, sum_rgb}) - $signed({3'b000, raw[sensor_cfg_pkg::CH_CLEAR]});
  assign ir_half = ir_wide >>> 1;

  // ****************************************
  // Per channel subtraction
  // ****************************************
  for (genvar ch = 0; ch < sensor_cfg_pkg::CH_COUNT; ch++) begin : g_ch
    logic signed [19:0] diff;
    assign diff = $signed({4'h0, raw[ch]}) - $signed({ir_half[18], ir_half});
    // Negative estimates can push a channel past full scale, so clamp both ends
    always_comb begin
      if (comp_off) begin
        corrected[ch] = raw[ch];
      end else if (diff[19]) begin
        corrected[ch] = 16'h0000;
      end else if (diff[18:16] != 3'h0) begin
        corrected[ch] = 16'hFFFF;
      end else begin
        corrected[ch] = diff[15:0];
      end
    end
  end

endmodule

// file: hw/near_avg_filter.sv
// Purpose: Averages near samples over a moving window or fixed groups.
// Assumes: At most one sample per clock, marked by sample_valid.
// Notes:   A moving window gives no result until the window has filled.
module near_avg_filter (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Samples in, results out
  near_path_if.filter fi
);

  // ****************************************
  // Window history and position
  // ****************************************
  sensor_cfg_pkg::near_type hist_reg [0:sensor_cfg_pkg::HIST_DEPTH-1];
  logic [1:0] pos_reg;
  logic       filled_reg;
  logic [1:0] last_pos;
  logic [9:0] sum_short;
  logic [9:0] sum_long;
  sensor_cfg_pkg::near_type avg;
  logic [9:0] sum_short_q;

  assign last_pos  = fi.avg_long ? sensor_cfg_pkg::LONG_LAST : sensor_cfg_pkg::SHORT_LAST;
  assign sum_short = {2'b00, fi.sample} + {2'b00, hist_reg[0]};
  assign sum_long  = sum_short + {2'b00, hist_reg[1]} + {2'b00, hist_reg[2]};
  // Powers of two keep the division a shift; the fraction is dropped
  assign avg = fi.avg_long ? sum_long[sensor_cfg_pkg::LONG_SHIFT +: sensor_cfg_pkg::NEAR_W]
                           : sum_short[sensor_cfg_pkg::SHORT_SHIFT +: sensor_cfg_pkg::NEAR_W];

  // Shift register of the previous samples
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < sensor_cfg_pkg::HIST_DEPTH; i++) begin
        hist_reg[i] <= '0;
      end
    end else if (fi.sample_valid) begin
      hist_reg[0] <= fi.sample;
      for (int i = 1; i < sensor_cfg_pkg::HIST_DEPTH; i++) begin
        hist_reg[i] <= hist_reg[i-1];
      end
    end
  end

  // Position in the group, wrapping at the selected length
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pos_reg    <= 2'b00;
      filled_reg <= 1'b0;
    end else if (fi.sample_valid) begin
      pos_reg <= (pos_reg >= last_pos) ? 2'b00 : pos_reg + 2'b01;
      if (pos_reg >= last_pos) begin
        filled_reg <= 1'b1;
      end
    end
  end

  // ****************************************
  // Result
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fi.result_valid <= 1'b0;
      fi.result       <= '0;
    end else begin
      fi.result_valid <= 1'b0;
      if (fi.sample_valid) begin
        if (!fi.avg_enable) begin
          fi.result_valid <= 1'b1;
          fi.result       <= fi.sample;
        end else if (fi.decimate ? (pos_reg >= last_pos)
                                 : (filled_reg || pos_reg >= last_pos)) begin
          fi.result_valid <= 1'b1;
          fi.result       <= avg;
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  raw_passes_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fi.sample_valid && !fi.avg_enable |=> fi.result_valid && fi.result == $past(fi.sample))
    else $error("raw sample not passed through");

  short_avg_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fi.sample_valid && fi.avg_enable && !fi.avg_long && !fi.decimate && filled_reg
    |=> fi.result_valid && fi.result == sum_short_q[8:1])
    else $error("two sample average wrong");

  group_skip_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fi.sample_valid && fi.avg_enable && fi.decimate && pos_reg < last_pos |=> !fi.result_valid)
    else $error("decimated result inside group");

  // Helper copy of the short sum for the average check
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sum_short_q <= 10'h000;
    end else begin
      sum_short_q <= sum_short;
    end
  end

endmodule

// file: hw/sensor_int_routing_near_avg_enable.sv
// Purpose: Interrupt pin routing, light integration abort and restart,
//          light infrared compensation and near sample averaging.
// Assumes: The serial bus front end presents one register access per
//          clock; engines signal results with one-cycle strobes.
// Notes:   Pins are active low push-pull copies of the interrupt levels.
module sensor_int_routing_near_avg_enable (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  // Register port from the serial bus front end
  input  wire logic [7:0]                    reg_addr,
  input  wire logic                          reg_wr,
  input  wire logic [7:0]                    reg_wdata,
  output logic      [7:0]                    reg_rdata,
  // Light engine
  input  wire logic                          light_done,
  input  wire logic                          light_active,
  input  wire sensor_cfg_pkg::color_set_type light_raw,
  input  wire sensor_cfg_pkg::color_type     light_thr_low,
  input  wire sensor_cfg_pkg::color_type     light_thr_high,
  output sensor_cfg_pkg::color_set_type      light_result,
  output logic                               light_abort,
  output logic                               light_restart,
  // Near engine
  input  wire logic                          near_sample_valid,
  input  wire sensor_cfg_pkg::near_type      near_sample,
  input  wire sensor_cfg_pkg::near_type      near_thr_low,
  input  wire sensor_cfg_pkg::near_type      near_thr_high,
  output sensor_cfg_pkg::near_type           near_result,
  output logic                               near_result_valid,
  // Disruptions
  input  wire logic                          gesture_active,
  input  wire logic                          pattern_busy,
  // Pins
  input  wire logic                          other_irq,
  output logic                               irq_n,
  output logic                               aux_n
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_reg;
  logic       rst_n_sync;

  // Two stage release so the rest of the block leaves reset cleanly
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_sync_reg[1];

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [7:0] routing_reg;
  logic [7:0] processing_reg;
  logic [7:0] rdata_reg;

  // Writes keep only implemented bits so reserved bits read as zero
  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      routing_reg    <= sensor_cfg_pkg::ROUTING_RESET;
      processing_reg <= sensor_cfg_pkg::PROCESSING_RESET;
    end else if (reg_wr) begin
      if (reg_addr == sensor_cfg_pkg::ROUTING_OFFSET) begin
        routing_reg <= reg_wdata & sensor_cfg_pkg::ROUTING_MASK;
      end
      if (reg_addr == sensor_cfg_pkg::PROCESSING_OFFSET) begin
        processing_reg <= reg_wdata & sensor_cfg_pkg::PROCESSING_MASK;
      end
    end
  end

  // Read data is registered; unmapped addresses read zero
  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      rdata_reg <= sensor_cfg_pkg::UNMAPPED_READ;
    end else if (reg_addr == sensor_cfg_pkg::ROUTING_OFFSET) begin
      rdata_reg <= routing_reg;
    end else if (reg_addr == sensor_cfg_pkg::PROCESSING_OFFSET) begin
      rdata_reg <= processing_reg;
    end else begin
      rdata_reg <= sensor_cfg_pkg::UNMAPPED_READ;
    end
  end
  assign reg_rdata = rdata_reg;

  // Field decode
  logic light_irq_level_mode;
  logic light_irq_level_on_aux_pin;
  logic near_irq_level_mode;
  logic near_irq_level_on_aux_pin;
  logic light_abort_on_disruption;
  logic infrared_comp_off;
  assign light_irq_level_mode       = routing_reg[sensor_cfg_pkg::LIGHT_LEVEL_BIT];
  assign light_irq_level_on_aux_pin = routing_reg[sensor_cfg_pkg::LIGHT_AUX_BIT];
  assign near_irq_level_mode        = routing_reg[sensor_cfg_pkg::NEAR_LEVEL_BIT];
  assign near_irq_level_on_aux_pin  = routing_reg[sensor_cfg_pkg::NEAR_AUX_BIT];
  assign light_abort_on_disruption  = processing_reg[sensor_cfg_pkg::ABORT_BIT];
  assign infrared_comp_off          = processing_reg[sensor_cfg_pkg::IRCOMP_OFF_BIT];

  // ****************************************
  // Light results and window state
  // ****************************************
  sensor_cfg_pkg::color_set_type light_corr;
  sensor_cfg_pkg::color_set_type light_result_reg;
  logic                          light_out_next;
  logic                          light_state_reg;

  color_ir_correct u_ir (
    .comp_off  (infrared_comp_off),
    .raw       (light_raw),
    .corrected (light_corr)
  );

  // The window test uses the incoming clear value, after compensation, not the stored one
  assign light_out_next = (light_corr[sensor_cfg_pkg::CH_CLEAR] < light_thr_low)
                       || (light_corr[sensor_cfg_pkg::CH_CLEAR] > light_thr_high);

  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      light_result_reg <= '0;
      light_state_reg  <= 1'b0;
    end else if (light_done) begin
      light_result_reg <= light_corr;
      light_state_reg  <= light_out_next;
    end
  end
  assign light_result = light_result_reg;

  // ****************************************
  // Near filtering and hysteresis
  // ****************************************
  near_path_if                 near_bus ();
  sensor_cfg_pkg::near_type    near_result_reg;
  logic                        near_valid_reg;
  logic                        near_state_reg;

  assign near_bus.sample_valid = near_sample_valid;
  assign near_bus.sample       = near_sample;
  assign near_bus.avg_enable   = processing_reg[sensor_cfg_pkg::AVG_ENABLE_BIT];
  assign near_bus.avg_long     = processing_reg[sensor_cfg_pkg::LENGTH_BIT];
  assign near_bus.decimate     = processing_reg[sensor_cfg_pkg::DECIMATE_BIT];

  near_avg_filter u_filter (
    .mclk  (mclk),
    .rst_n (rst_n_sync),
    .fi    (near_bus.filter)
  );

  // Result and threshold check move only when the filter gives a value
  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      near_result_reg <= '0;
      near_valid_reg  <= 1'b0;
    end else begin
      near_valid_reg <= near_bus.result_valid;
      if (near_bus.result_valid) begin
        near_result_reg <= near_bus.result;
      end
    end
  end
  assign near_result       = near_result_reg;
  assign near_result_valid = near_valid_reg;

  // Set above upper, clear below lower, hold in between
  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      near_state_reg <= 1'b0;
    end else if (near_bus.result_valid) begin
      if (near_bus.result > near_thr_high) begin
        near_state_reg <= 1'b1;
      end else if (near_bus.result < near_thr_low) begin
        near_state_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Pin routing
  // ****************************************
  logic light_to_irq;
  logic light_to_aux;
  logic near_to_irq;
  logic near_to_aux;
  logic irq_n_reg;
  logic aux_n_reg;

  // Aux routing alone also selects level behaviour for that source
  assign light_to_irq = light_irq_level_mode && !light_irq_level_on_aux_pin && light_state_reg;
  assign light_to_aux = light_irq_level_on_aux_pin && light_state_reg;
  assign near_to_irq  = near_irq_level_mode && !near_irq_level_on_aux_pin && near_state_reg;
  assign near_to_aux  = near_irq_level_on_aux_pin && near_state_reg;

  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      irq_n_reg <= 1'b1;
      aux_n_reg <= 1'b1;
    end else begin
      irq_n_reg <= !(other_irq || light_to_irq || near_to_irq);
      aux_n_reg <= !(light_to_aux || near_to_aux);
    end
  end
  assign irq_n = irq_n_reg;
  assign aux_n = aux_n_reg;

  // ****************************************
  // Light abort and restart
  // ****************************************
  logic disrupt;
  logic disrupt_reg;
  logic abort_reg;
  logic restart_reg;

  assign disrupt = gesture_active || pattern_busy;

  // Abort is held for as long as an integration runs into a disruption
  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      disrupt_reg <= 1'b0;
      abort_reg   <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      disrupt_reg <= disrupt;
      abort_reg   <= light_abort_on_disruption && disrupt && light_active;
      // Restart bypasses the wait, so extra measurements can appear
      restart_reg <= light_abort_on_disruption && disrupt_reg && !disrupt;
    end
  end
  assign light_abort   = abort_reg;
  assign light_restart = restart_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n_sync);

  sequence light_leaves_s;
    light_done && light_out_next;
  endsequence

  sequence light_inside_s;
    light_done && !light_out_next;
  endsequence

  sequence disruption_ends_s;
    light_abort_on_disruption && disrupt ##1 light_abort_on_disruption && !disrupt;
  endsequence

  light_exit_a: assert property (
    light_leaves_s ##1 light_irq_level_mode && !light_irq_level_on_aux_pin && !other_irq |=> !irq_n)
    else $error("irq pin not asserted on window exit");

  light_reenter_a: assert property (
    light_inside_s ##1 light_irq_level_mode && !light_irq_level_on_aux_pin && !other_irq && !near_to_irq
    |=> irq_n)
    else $error("irq pin not released inside window");

  light_follow_a: assert property (
    light_to_irq |=> !irq_n)
    else $error("irq pin does not follow light state");

  light_aux_a: assert property (
    light_irq_level_on_aux_pin && light_state_reg |=> !aux_n)
    else $error("aux pin does not show light state");

  near_set_a: assert property (
    near_bus.result_valid && near_bus.result > near_thr_high |=> near_state_reg)
    else $error("near state not set above upper");

  near_hold_a: assert property (
    near_state_reg && !(near_bus.result_valid && near_bus.result < near_thr_low) |=> near_state_reg)
    else $error("near state released early");

  near_aux_a: assert property (
    near_irq_level_on_aux_pin && near_state_reg && !other_irq && !light_to_irq |=> !aux_n && irq_n)
    else $error("near state not moved to aux pin");

  light_abort_a: assert property (
    light_abort_on_disruption && disrupt && light_active |=> light_abort)
    else $error("integration not aborted");

  light_restart_a: assert property (
    disruption_ends_s |=> light_restart ##1 (!light_restart || disrupt_reg))
    else $error("restart missing after disruption");

  ir_bypass_a: assert property (
    light_done && infrared_comp_off |=> light_result == $past(light_raw))
    else $error("compensation applied while off");

  near_store_a: assert property (
    near_bus.result_valid |=> near_result == $past(near_bus.result) && near_result_valid)
    else $error("near result not updated");

  near_release_a: assert property (
    near_bus.result_valid && near_bus.result < near_thr_low |=> !near_state_reg)
    else $error("near state not released below lower");

  near_irq_a: assert property (
    near_irq_level_mode && !near_irq_level_on_aux_pin && near_state_reg |=> !irq_n)
    else $error("irq pin does not show near state");

  pin_idle_a: assert property (
    !other_irq && !light_to_irq && !near_to_irq |=> irq_n)
    else $error("irq pin asserted with no source");

  abort_off_a: assert property (
    !light_abort_on_disruption |=> !light_abort && !light_restart)
    else $error("abort or restart while disabled");

endmodule

// file: dv/host_model.sv
// Purpose: Host side of the register port, with access tasks.
// Assumes: The device samples the port on the rising edge.
// Notes:   The port only changes on the falling edge.
module host_model (
  // Clock and read data
  input  wire logic       mclk,
  input  wire logic [7:0] reg_rdata,
  // Register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle port on an unmapped place
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
  end
  // Strobe spans one rising edge; data is scrambled after, not left valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge mclk);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask
  // Read data is registered, so two edges pass before sampling
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    repeat (2) @(negedge mclk);
    d = reg_rdata;
  endtask
endmodule

// file: dv/tb_top.sv
// Purpose: Self-checking bench for routing, compensation and averaging.
// Assumes: Handed-over latencies; inputs move on the falling edge.
// Notes:   Expected values are worked out here from the written settings.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst_n, reg_wr, light_done, light_active, nsv, gesture_active, pattern_busy;
  logic light_abort, light_restart, near_result_valid, irq_n, aux_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
  sensor_cfg_pkg::color_set_type light_raw, light_result;
  sensor_cfg_pkg::near_type near_sample, near_result;
  int n_mismatch = 0, compares = 0, nv = 0, rs = 0;
  // Clear 60 after compensation (inside), and clear 0 (below the window)
  localparam logic [63:0] IN_WIN = {{3{16'h003C}}, 16'h0064};
  localparam logic [63:0] LOW = {4{16'h0020}};

  sensor_int_routing_near_avg_enable dut (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
    .light_done, .light_active, .light_raw, .light_thr_low(16'h0032), .light_thr_high(16'h00C8),
    .light_result, .light_abort, .light_restart, .near_sample_valid(nsv), .near_sample,
    .near_thr_low(8'h0A), .near_thr_high(8'h14), .near_result, .near_result_valid,
    .gesture_active, .pattern_busy, .other_irq(1'b0), .irq_n, .aux_n);
  host_model host (.mclk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata);

  // Free-running 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Counts result strobes and restart pulses
  always @(posedge mclk) begin
    if (near_result_valid === 1'b1) nv++;
    if (light_restart === 1'b1) rs++;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One engine strobe, then wait out the two-edge answer
  task automatic strobe(input bit near, input logic [63:0] v);
    @(negedge mclk);
    nsv = near;
    light_done = !near;
    near_sample = v[7:0];
    light_raw = v;
    @(negedge mclk);
    nsv = 1'b0;
    light_done = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  // Hang guard, far beyond the roughly 135 cycles needed
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
  // Main sequence
  initial begin
    {rst_n, light_done, light_active, nsv, gesture_active, pattern_busy} = '0;
    light_raw = '0;
    near_sample = '0;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    host.rd(8'hAD, rd_val);
    chk(rd_val, 8'h08);
    host.rd(8'hAB, rd_val);
    chk(rd_val, 8'h00);
    host.wr(8'hAD, 8'hFF);
    host.rd(8'hAD, rd_val);
    chk(rd_val, 8'h2F);
    host.wr(8'hAD, 8'h00);
    host.wr(8'hAC, 8'h80);
    strobe(0, IN_WIN);
    chk(light_result[0], 16'h003C);
    chk(light_result[1], 16'h0014);
    chk(irq_n, 1'b1);
    strobe(0, LOW);
    chk(irq_n, 1'b0);
    strobe(0, IN_WIN);
    chk(irq_n, 1'b1);
    host.wr(8'hAC, 8'hC0);
    strobe(0, LOW);
    chk({irq_n, aux_n}, 2'b10);
    host.wr(8'hAC, 8'h20);
    strobe(1, 8'h19);
    chk(near_result, 8'h19);
    chk(irq_n, 1'b0);
    strobe(1, 8'h0F);
    chk(irq_n, 1'b0);
    strobe(1, 8'h05);
    chk(irq_n, 1'b1);
    host.wr(8'hAC, 8'h30);
    strobe(1, 8'h19);
    chk({irq_n, aux_n}, 2'b10);
    strobe(1, 8'h05);
    host.wr(8'hAD, 8'h01);
    strobe(1, 8'h0A);
    chk(near_result, 8'h07);
    host.wr(8'hAD, 8'h07);
    nv = 0;
    repeat (8) strobe(1, 8'h09);
    chk(16'(nv), 16'd2);
    host.wr(8'hAD, 8'h03);
    nv = 0;
    repeat (3) strobe(1, 8'h0B);
    chk(16'(nv), 16'd3);
    chk(near_result, 8'h0A);
    host.wr(8'hAD, 8'h20);
    light_active = 1'b1;
    gesture_active = 1'b1;
    repeat (2) @(negedge mclk);
    chk(light_abort, 1'b1);
    pattern_busy = 1'b1;
    gesture_active = 1'b0;
    rs = 0;
    @(negedge mclk);
    chk(light_abort, 1'b1);
    pattern_busy = 1'b0;
    repeat (4) @(negedge mclk);
    chk(16'(rs), 16'd1);
    end_sim();
  end
endmodule
